/* File: hdl/hss_cfg.svh */
// constants for the hot-swap signal sequencer
`ifndef HSS_CFG_SVH
`define HSS_CFG_SVH
`define HSS_CLK_MHZ        200
`define HSS_US_CYC         (`HSS_CLK_MHZ)
`define HSS_MS_US          1000
`define HSS_NSRC           6
`define HSS_NSIG           8
`define HSS_ERR_RANGE      8'h16
`define HSS_ERR_STATE      8'h41
`define HSS_ERR_NONE       8'h00
`define HSS_R_CTRL         8'h00
`define HSS_R_STAT         8'h04
`define HSS_R_SRCEN        8'h08
`define HSS_R_GLEN         8'h0C
`define HSS_R_GMUL         8'h10
`define HSS_R_GCYC         8'h14
`define HSS_R_GPRBS        8'h18
`define HSS_R_GDUR         8'h1C
`define HSS_R_SRC0         8'h40
`define HSS_R_SIG0         8'h80
`define HSS_SRC_STRIDE     4'h4
`define HSS_DLY_MAX        16'h2710
`define HSS_BLEN_MAX       16'h2710
`define HSS_BPER_MAX       16'hFFFF
`define HSS_DUTY_MAX       8'h64
`define HSS_SRC_OFF        3'h0
`define HSS_SRC_IMM        3'h7
`endif

/* File: hdl/hss_pkg.sv */
// types for the hot-swap signal sequencer
package hss_pkg;
   typedef enum logic [1:0] {
      HSS_ST_IDLE = 2'b00,
      HSS_ST_WAIT = 2'b01,
      HSS_ST_BNC  = 2'b10,
      HSS_ST_DONE = 2'b11
   } hss_src_st_t;
   typedef enum logic [1:0] {
      HSS_PIN_CONN = 2'b00,
      HSS_PIN_OPEN = 2'b01,
      HSS_PIN_HIGH = 2'b10,
      HSS_PIN_LOW  = 2'b11
   } hss_pin_t;
   typedef struct packed {
      logic [15:0] dly_ms;
      logic [15:0] blen_ms;
      logic [15:0] bper_us;
      logic [7:0]  duty;
   } hss_src_cfg_t;
   // msb first, so the packed word lines up with the signal register bits
   typedef struct packed {
      logic       gl_drv;
      logic       gl_lvl;
      logic       gl_con;
      logic       drv_out;
      logic       drv_lvl;
      logic       drv_en;
      logic [2:0] src;
   } hss_sig_cfg_t;
endpackage

/* File: hdl/hss_sequencer.sv */
// hot-swap signal sequencer: timed sources, signal switching, glitch generator
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "hss_cfg.svh"
module hss_sequencer (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   clk_en,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic      [`HSS_NSIG-1:0]   pin_link_en,
   output logic      [`HSS_NSIG-1:0]   pin_src_open,
   output logic      [`HSS_NSIG-1:0]   pin_drv_oe,
   output logic      [`HSS_NSIG-1:0]   pin_drv_lvl,
   output logic      [`HSS_NSIG-1:0]   pin_drv_out,
   output logic                        glitch_active
);
   localparam int NS = `HSS_NSRC;
   localparam int NG = `HSS_NSIG;

   hss_pkg::hss_src_cfg_t src_cfg_reg [NS];
   hss_pkg::hss_src_st_t  src_st_reg  [NS];
   hss_pkg::hss_sig_cfg_t sig_cfg_reg [NG];
   logic [NS-1:0]  src_en_reg;
   logic [NS-1:0]  src_conn_reg;
   logic [15:0]    src_ms_reg  [NS];
   logic [9:0]     src_us_reg  [NS];
   logic [15:0]    src_pc_reg  [NS];
   logic           plugged_reg;
   logic           imm_conn_reg;
   logic [7:0]     err_reg;
   logic [7:0]     us_div_reg;
   logic           us_tick;
   logic [15:0]    gl_len_reg;
   logic [3:0]     gl_mul_reg;
   logic [15:0]    gl_cyc_reg;
   logic [1:0]     gl_prbs_reg;
   logic [1:0]     gl_mode_reg;
   logic [31:0]    gl_cnt_reg;
   logic [15:0]    gl_gap_reg;
   logic [15:0]    lfsr_reg;
   logic           wr_pend_reg;
   logic [7:0]     wr_addr_reg;

   function automatic logic [31:0] gl_dur(input logic [15:0] len, input logic [3:0] mul);
      gl_dur = 32'(len) * 32'(mul);
   endfunction

   function automatic logic [31:0] gl_ticks(input logic [31:0] dur_us);
      gl_ticks = dur_us * 32'(`HSS_US_CYC);
   endfunction

   function automatic logic in_range(input logic [15:0] v, input logic [15:0] mx);
      in_range = (v <= mx);
   endfunction

   // one microsecond timebase for the source timers and the glitch gap counter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         us_div_reg <= 8'h00;
      end else if (clk_en) begin
         if (us_tick) begin
            us_div_reg <= 8'h00;
         end else begin
            us_div_reg <= us_div_reg + 8'h01;
         end
      end
   end
   assign us_tick = (us_div_reg == 8'(`HSS_US_CYC - 1));

   // AHB-Lite slave: zero wait states, writes take effect one cycle after the address phase
   logic ap_valid;
   logic ap_wr;
   assign ap_valid = hsel && htrans[1] && hready;
   assign ap_wr    = ap_valid && hwrite;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else if (clk_en) begin
         wr_pend_reg <= ap_wr;
         if (ap_valid) begin
            wr_addr_reg <= haddr[7:0];
         end
      end
   end

   logic       wr_now;
   logic [7:0] wa;
   logic [2:0] wsrc;
   logic [2:0] wsig;
   assign wr_now = wr_pend_reg;
   assign wa     = wr_addr_reg;
   assign wsrc   = 3'(wa[4:2]);
   assign wsig   = 3'(wa[4:2]);

   logic do_plug;
   logic do_pull;
   logic gl_once_req;
   logic gl_cyc_req;
   logic gl_prbs_req;
   logic gl_stop_req;
   assign do_plug     = wr_now && wa == `HSS_R_CTRL && hwdata[0];
   assign do_pull     = wr_now && wa == `HSS_R_CTRL && hwdata[1];
   assign gl_once_req = wr_now && wa == `HSS_R_CTRL && hwdata[2];
   assign gl_cyc_req  = wr_now && wa == `HSS_R_CTRL && hwdata[3];
   assign gl_prbs_req = wr_now && wa == `HSS_R_CTRL && hwdata[4];
   assign gl_stop_req = wr_now && wa == `HSS_R_CTRL && hwdata[5];

   // configuration, range checks and error code
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         src_en_reg  <= '0;
         gl_len_reg  <= 16'h0001;
         gl_mul_reg  <= 4'h1;
         gl_cyc_reg  <= 16'h0064;
         gl_prbs_reg <= 2'h0;
         err_reg     <= `HSS_ERR_NONE;
         for (int i = 0; i < NS; i++) begin
            src_cfg_reg[i] <= '0;
         end
         for (int j = 0; j < NG; j++) begin
            sig_cfg_reg[j] <= '0;
         end
      end else if (clk_en && wr_now) begin
         err_reg <= `HSS_ERR_NONE;
         if (wa == `HSS_R_CTRL) begin
            if ((hwdata[0] && plugged_reg) || (hwdata[1] && !plugged_reg)) begin
               err_reg <= `HSS_ERR_STATE;
            end else if (hwdata[5] && gl_mode_reg == 2'h0) begin
               err_reg <= `HSS_ERR_STATE;
            end
         end else if (wa == `HSS_R_SRCEN) begin
            src_en_reg <= hwdata[NS-1:0];
         end else if (wa == `HSS_R_GLEN) begin
            gl_len_reg <= hwdata[15:0];
         end else if (wa == `HSS_R_GMUL) begin
            if (hwdata[3:0] == 4'h1 || hwdata[3:0] == 4'h2 || hwdata[3:0] == 4'h4
                || hwdata[3:0] == 4'h8) begin
               gl_mul_reg <= hwdata[3:0];
            end else begin
               err_reg <= `HSS_ERR_RANGE;
            end
         end else if (wa == `HSS_R_GCYC) begin
            if (hwdata[15:0] != 16'h0000) begin
               gl_cyc_reg <= hwdata[15:0];
            end else begin
               err_reg <= `HSS_ERR_RANGE;
            end
         end else if (wa == `HSS_R_GPRBS) begin
            gl_prbs_reg <= hwdata[1:0];
         end else if (wa[7:6] == 2'b01 && wa[5] == 1'b0 && wsrc < 3'(NS)) begin
            // per source: word 0 delay/length/clear, word 1 period/duty (wa[5] picks set)
            if (hwdata[31]) begin
               src_cfg_reg[wsrc].blen_ms <= 16'h0000;
               src_cfg_reg[wsrc].bper_us <= 16'h0000;
               src_cfg_reg[wsrc].duty    <= 8'h00;
            end else if (!in_range(hwdata[15:0], `HSS_DLY_MAX)
                         || !in_range({1'b0, hwdata[30:16]}, `HSS_BLEN_MAX)) begin
               err_reg <= `HSS_ERR_RANGE;
            end else begin
               src_cfg_reg[wsrc].dly_ms  <= hwdata[15:0];
               src_cfg_reg[wsrc].blen_ms <= {1'b0, hwdata[30:16]};
            end
         end else if (wa[7:6] == 2'b01 && wa[5] == 1'b1 && wsrc < 3'(NS)) begin
            if (hwdata[23:16] > `HSS_DUTY_MAX) begin
               err_reg <= `HSS_ERR_RANGE;
            end else begin
               src_cfg_reg[wsrc].bper_us <= hwdata[15:0];
               src_cfg_reg[wsrc].duty    <= hwdata[23:16];
            end
         end else if (wa[7:5] == 3'b100) begin
            if (hwdata[2:0] > 3'(NS) && hwdata[2:0] != `HSS_SRC_IMM) begin
               err_reg <= `HSS_ERR_RANGE;
            end else begin
               sig_cfg_reg[wsig] <= hss_pkg::hss_sig_cfg_t'(hwdata[8:0]);
            end
         end
      end
   end

   // hot-swap action state: plug connects, pull disconnects
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         plugged_reg  <= 1'b0;
         imm_conn_reg <= 1'b0;
      end else if (clk_en) begin
         if (do_plug && !plugged_reg) begin
            plugged_reg  <= 1'b1;
            imm_conn_reg <= 1'b1;
         end else if (do_pull && plugged_reg) begin
            plugged_reg  <= 1'b0;
            imm_conn_reg <= 1'b0;
         end
      end
   end

   // timed sources: delay, then bounce, then settle at target
   logic start_act;
   assign start_act = (do_plug && !plugged_reg) || (do_pull && plugged_reg);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         src_conn_reg <= '0;
         for (int i = 0; i < NS; i++) begin
            src_st_reg[i] <= hss_pkg::HSS_ST_IDLE;
            src_ms_reg[i] <= 16'h0000;
            src_us_reg[i] <= 10'h000;
            src_pc_reg[i] <= 16'h0000;
         end
      end else if (clk_en) begin
         for (int i = 0; i < NS; i++) begin
            case (src_st_reg[i])
               hss_pkg::HSS_ST_IDLE, hss_pkg::HSS_ST_DONE: begin
                  if (start_act && src_en_reg[i]) begin
                     src_st_reg[i] <= hss_pkg::HSS_ST_WAIT;
                     src_ms_reg[i] <= 16'h0000;
                     src_us_reg[i] <= 10'h000;
                  end
               end
               hss_pkg::HSS_ST_WAIT: begin
                  if (src_ms_reg[i] >= src_cfg_reg[i].dly_ms) begin
                     src_st_reg[i] <= hss_pkg::HSS_ST_BNC;
                     src_ms_reg[i] <= 16'h0000;
                     src_pc_reg[i] <= 16'h0000;
                  end
               end
               hss_pkg::HSS_ST_BNC: begin
                  if (src_ms_reg[i] >= src_cfg_reg[i].blen_ms
                      || src_cfg_reg[i].bper_us == 16'h0000) begin
                     src_st_reg[i]   <= hss_pkg::HSS_ST_DONE;
                     src_conn_reg[i] <= plugged_reg;
                  end else begin
                     // in target state for the first duty percent of each period
                     src_conn_reg[i] <= ((32'(src_pc_reg[i]) * 32'(`HSS_DUTY_MAX))
                                        < (32'(src_cfg_reg[i].bper_us) * 32'(src_cfg_reg[i].duty)))
                                        ? plugged_reg : !plugged_reg;
                  end
               end
               default: src_st_reg[i] <= hss_pkg::HSS_ST_IDLE;
            endcase
            if (us_tick && src_st_reg[i] != hss_pkg::HSS_ST_IDLE
                && src_st_reg[i] != hss_pkg::HSS_ST_DONE) begin
               if (src_pc_reg[i] + 16'h0001 >= src_cfg_reg[i].bper_us) begin
                  src_pc_reg[i] <= 16'h0000;
               end else begin
                  src_pc_reg[i] <= src_pc_reg[i] + 16'h0001;
               end
               if (src_us_reg[i] == 10'(`HSS_MS_US - 1)) begin
                  src_us_reg[i] <= 10'h000;
                  src_ms_reg[i] <= src_ms_reg[i] + 16'h0001;
               end else begin
                  src_us_reg[i] <= src_us_reg[i] + 10'h001;
               end
            end
         end
      end
   end

   // glitch generator: 0 off, 1 cyclic, 2 prbs; once skips the gap counter and shares the length counter
   logic gl_fire;
   assign gl_fire = (gl_mode_reg == 2'h1) || (gl_mode_reg == 2'h2 && lfsr_reg[0]);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gl_mode_reg   <= 2'h0;
         gl_cnt_reg    <= 32'h0;
         gl_gap_reg    <= 16'h0;
         lfsr_reg      <= 16'hACE1;
         glitch_active <= 1'b0;
      end else if (clk_en) begin
         if (gl_stop_req) begin
            gl_mode_reg <= 2'h0;
         end else if (gl_prbs_req) begin
            gl_mode_reg <= 2'h2;
         end else if (gl_cyc_req) begin
            gl_mode_reg <= 2'h1;
         end
         // length counted in clock cycles: the timebase phase must not shorten a glitch
         if (gl_once_req && !glitch_active) begin
            glitch_active <= 1'b1;
            gl_cnt_reg    <= gl_ticks(gl_dur(gl_len_reg, gl_mul_reg));
         end else if (glitch_active) begin
            if (gl_cnt_reg <= 32'h1) begin
               glitch_active <= 1'b0;
            end
            gl_cnt_reg <= gl_cnt_reg - 32'h1;
         end
         if (us_tick) begin
            if (gl_gap_reg + 16'h0001 >= gl_cyc_reg) begin
               gl_gap_reg <= 16'h0000;
               // pattern type picks the feedback taps of the sequence
               case (gl_prbs_reg)
                  2'h0:    lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[6] ^ lfsr_reg[5]};
                  2'h1:    lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[8] ^ lfsr_reg[4]};
                  2'h2:    lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[14] ^ lfsr_reg[13]};
                  default: lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[14]
                                        ^ lfsr_reg[12] ^ lfsr_reg[3]};
               endcase
               if (gl_fire && !glitch_active) begin
                  glitch_active <= 1'b1;
                  gl_cnt_reg    <= gl_ticks(gl_dur(gl_len_reg, gl_mul_reg));
               end
            end else begin
               gl_gap_reg <= gl_gap_reg + 16'h0001;
            end
         end
      end
   end

   // signal pins follow assigned source; drive breaks source side first
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_link_en  <= '0;
         pin_src_open <= '1;
         pin_drv_oe   <= '0;
         pin_drv_lvl  <= '0;
         pin_drv_out  <= '0;
      end else if (clk_en) begin
         for (int j = 0; j < NG; j++) begin
            logic       conn;
            logic       want_drv;
            logic       lvl;
            conn = 1'b0;
            if (sig_cfg_reg[j].src == `HSS_SRC_IMM) begin
               conn = imm_conn_reg;
            end else if (sig_cfg_reg[j].src != `HSS_SRC_OFF) begin
               conn = src_conn_reg[3'(sig_cfg_reg[j].src - 3'h1)];
            end
            want_drv = sig_cfg_reg[j].drv_en;
            lvl      = sig_cfg_reg[j].drv_lvl;
            if (glitch_active && sig_cfg_reg[j].gl_con) begin
               want_drv = sig_cfg_reg[j].gl_drv;
               lvl      = sig_cfg_reg[j].gl_lvl;
               conn     = 1'b0;
            end
            pin_drv_out[j] <= sig_cfg_reg[j].drv_out;
            pin_drv_lvl[j] <= lvl;
            if (want_drv) begin
               pin_link_en[j]  <= 1'b0;
               pin_src_open[j] <= 1'b1;
               pin_drv_oe[j]   <= pin_src_open[j] && !pin_link_en[j];
            end else begin
               pin_drv_oe[j]   <= 1'b0;
               pin_src_open[j] <= !conn;
               pin_link_en[j]  <= conn && !pin_drv_oe[j];
            end
         end
      end
   end

   // read data registered in the data phase
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hrdata <= 32'h0;
      end else if (clk_en && ap_valid && !hwrite) begin
         hrdata <= 32'h0;
         if (haddr[7:0] == `HSS_R_STAT) begin
            hrdata <= {8'h00, 2'b00, gl_mode_reg, glitch_active, plugged_reg, imm_conn_reg,
                       1'b0, 2'b00, 6'(src_conn_reg), err_reg};
         end else if (haddr[7:0] == `HSS_R_SRCEN) begin
            hrdata <= 32'(src_en_reg);
         end else if (haddr[7:0] == `HSS_R_GLEN) begin
            hrdata <= 32'(gl_len_reg);
         end else if (haddr[7:0] == `HSS_R_GMUL) begin
            hrdata <= 32'(gl_mul_reg);
         end else if (haddr[7:0] == `HSS_R_GCYC) begin
            hrdata <= 32'(gl_cyc_reg);
         end else if (haddr[7:0] == `HSS_R_GPRBS) begin
            hrdata <= 32'(gl_prbs_reg);
         end else if (haddr[7:0] == `HSS_R_GDUR) begin
            hrdata <= gl_dur(gl_len_reg, gl_mul_reg);
         end else if (haddr[7:6] == 2'b01 && 3'(haddr[4:2]) < 3'(NS)) begin
            if (haddr[5]) begin
               hrdata <= {8'h00, src_cfg_reg[3'(haddr[4:2])].duty,
                          src_cfg_reg[3'(haddr[4:2])].bper_us};
            end else begin
               hrdata <= {1'b0, src_cfg_reg[3'(haddr[4:2])].blen_ms[14:0],
                          src_cfg_reg[3'(haddr[4:2])].dly_ms};
            end
         end else if (haddr[7:5] == 3'b100) begin
            hrdata <= {23'h0, sig_cfg_reg[3'(haddr[4:2])]};
         end
      end
   end
endmodule // hss_sequencer
`default_nettype wire

/* File: tb/hss_checker.sv */
// assertions on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "hss_cfg.svh"
module hss_checker (
   input wire logic                 clk,
   input wire logic                 sys_rst,
   input wire logic                 clk_en,
   input wire logic                 hsel,
   input wire logic [31:0]          haddr,
   input wire logic [1:0]           htrans,
   input wire logic                 hwrite,
   input wire logic [31:0]          hwdata,
   input wire logic                 hready,
   input wire logic [31:0]          hrdata,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire logic [`HSS_NSIG-1:0] pin_link_en,
   input wire logic [`HSS_NSIG-1:0] pin_src_open,
   input wire logic [`HSS_NSIG-1:0] pin_drv_oe,
   input wire logic                 glitch_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_sig2_wr;
      hsel && htrans[1] && hready && clk_en && hwrite && haddr[7:0] == (`HSS_R_SIG0 + 8'h08);
   endsequence
   sequence s_drv_on;
      clk_en && hwdata[3] && hwdata[2:0] == 3'h0 && !hwdata[6];
   endsequence
   sequence s_drv_off;
      clk_en && !hwdata[3] && hwdata[2:0] == 3'h0 && !hwdata[6];
   endsequence
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   AST_DRV_AFTER_BREAK: assert property ((pin_drv_oe & ~$past(pin_drv_oe) & ~$past(pin_src_open)) == '0)
      else $error("drive started before source side opened");
   AST_DRV_NEEDS_OPEN: assert property ((pin_drv_oe & ~pin_src_open) == '0)
      else $error("driving with source side closed");
   AST_ONE_STATE: assert property ((pin_drv_oe & pin_link_en) == '0)
      else $error("line joined and driven at once");
   AST_RST_VALUES: assert property ($fell(sys_rst) |-> pin_link_en == '0 && pin_src_open == '1 && pin_drv_oe == '0 && !glitch_active && hrdata == 32'h0)
      else $error("wrong state after reset");
   AST_FROZEN: assert property (!clk_en |=> $stable(pin_link_en) && $stable(pin_drv_oe) && $stable(hrdata) && $stable(glitch_active))
      else $error("state moved while timebase stopped");
   AST_RDATA_STANDS: assert property (!$stable(hrdata) |-> $past(hsel && htrans[1] && hready && clk_en && !hwrite))
      else $error("read data changed without a read");
   AST_SIG2_DRIVE: assert property (s_sig2_wr ##1 s_drv_on |-> ##[1:20] pin_drv_oe[2])
      else $error("drive enable did not drive the line");
   AST_SIG2_OFF: assert property (s_sig2_wr ##1 s_drv_off |-> ##[1:20] !pin_drv_oe[2] && !pin_link_en[2])
      else $error("always-off source left the line active");
endmodule // hss_checker
bind hss_sequencer hss_checker u_chk (.clk, .sys_rst, .clk_en, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pin_link_en, .pin_src_open, .pin_drv_oe,
   .glitch_active);
`default_nettype wire

/* File: tb/hss_far_end.sv */
// far-side model of the switched connector lines
`timescale 1ns/100ps
`default_nettype none
`include "hss_cfg.svh"
module hss_far_end (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic [`HSS_NSIG-1:0] link_en,
   input  wire logic [`HSS_NSIG-1:0] drv_oe,
   input  wire logic [`HSS_NSIG-1:0] drv_lvl,
   output logic      [`HSS_NSIG-1:0] dev_side
);
   logic [`HSS_NSIG-1:0] pat_reg;
   logic [`HSS_NSIG-1:0] last_reg;
   // backplane toggles every cycle so a stale line never looks right
   always_ff @(posedge clk) begin
      pat_reg  <= sys_rst ? 8'h55 : ~pat_reg;
      last_reg <= sys_rst ? '0 : dev_side;
   end
   // joined, driven, or open: an open line shows the inverse of its last level
   assign dev_side = (link_en & pat_reg) | (~link_en & drv_oe & drv_lvl)
                   | (~link_en & ~drv_oe & ~last_reg);
endmodule // hss_far_end
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the sequencer
`timescale 1ns/100ps
`default_nettype none
`include "hss_cfg.svh"
module tb_top;
   logic                 clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]           htrans = 2'h0;
   logic [2:0]           hsize = 3'h2;
   logic                 hreadyout, hresp, glitch_active;
   logic [`HSS_NSIG-1:0] pin_link_en, pin_src_open, pin_drv_oe, pin_drv_lvl, pin_drv_out, far;
   logic [7:0]           ea [4] = '{`HSS_R_GMUL, `HSS_R_GCYC, 8'h60, `HSS_R_SRC0};
   logic [31:0]          ed [4] = '{32'h3, 32'h0, 32'h00650000, 32'h00002711};
   int                   miscompares = 0, check_count = 0, cyc = 0, n, k;
   always #2.5 clk = ~clk;
   hss_sequencer dut (.clk, .sys_rst, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_link_en, .pin_src_open, .pin_drv_oe,
      .pin_drv_lvl, .pin_drv_out, .glitch_active);
   hss_far_end u_far (.clk, .sys_rst, .link_en(pin_link_en), .drv_oe(pin_drv_oe),
      .drv_lvl(pin_drv_lvl), .dev_side(far));
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wr ? d : 32'h0;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(nm, exp, rd & m);
   endtask
   // bounded wait for glitch_active to reach a level
   task automatic wait_gl(input logic lvl, input int lim);
      for (n = 0; n < lim && glitch_active !== lvl; n++) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk("link_rst", 32'h0, pin_link_en);
      chk("open_rst", 32'hFF, pin_src_open);
      clk_en <= 1'b0;
      repeat (10) @(posedge clk);
      clk_en <= 1'b1;
      $display("test reset done");
      wr(`HSS_R_SRCEN, 32'h2A);
      rd_chk("srcen", `HSS_R_SRCEN, 32'h3F, 32'h2A);
      wr(`HSS_R_SRC0, 32'h0005_2710);
      rd_chk("err_ok", `HSS_R_STAT, 32'hFF, 32'h0);
      rd_chk("src0", `HSS_R_SRC0, 32'h7FFF_FFFF, 32'h0005_2710);
      wr(`HSS_R_SRC0, 32'h8000_2710);
      rd_chk("bclr", `HSS_R_SRC0, 32'h7FFF_0000, 32'h0);
      for (k = 0; k < 4; k++) begin
         wr(ea[k], ed[k]);
         rd_chk("err_rng", `HSS_R_STAT, 32'hFF, {24'h0, `HSS_ERR_RANGE});
      end
      $display("test config done");
      wr(`HSS_R_SIG0 + 8'h08, 32'h38);
      for (n = 0; n < 20 && pin_drv_oe[2] !== 1'b1; n++) @(posedge clk);
      chk("drv_oe", 32'h1, pin_drv_oe[2]);
      chk("drv_open", 32'h1, pin_src_open[2]);
      chk("drv_lvl_out", 32'h3, {pin_drv_out[2], pin_drv_lvl[2]});
      chk("far_hi", 32'h1, far[2]);
      rd_chk("sig2", `HSS_R_SIG0 + 8'h08, 32'h1FF, 32'h38);
      wr(`HSS_R_SIG0 + 8'h08, 32'h0);
      repeat (20) @(posedge clk);
      chk("drv_off", 32'h0, {pin_drv_oe[2], pin_link_en[2]});
      $display("test drive done");
      wr(`HSS_R_SIG0, {29'h0, `HSS_SRC_IMM});
      wr(`HSS_R_SIG0 + 8'h04, {29'h0, `HSS_SRC_OFF});
      wr(`HSS_R_SIG0 + 8'h0C, 32'h1);
      wr(`HSS_R_SIG0 + 8'h10, 32'h2);
      rd_chk("sig3_src", `HSS_R_SIG0 + 8'h0C, 32'h7, 32'h1);
      wr(`HSS_R_CTRL, 32'h1);
      for (n = 0; n < 400 && pin_link_en[0] !== 1'b1; n++) @(posedge clk);
      chk("plug_imm", 32'h1, pin_link_en[0]);
      chk("plug_off_dis", 32'h0, {pin_link_en[3], pin_link_en[1]});
      rd_chk("plugged", `HSS_R_STAT, 32'h4_3FFF, 32'h4_2A00);
      chk("plug_src", 32'h1, pin_link_en[4]);
      wr(`HSS_R_CTRL, 32'h1);
      rd_chk("err_plug", `HSS_R_STAT, 32'hFF, {24'h0, `HSS_ERR_STATE});
      wr(`HSS_R_CTRL, 32'h2);
      for (n = 0; n < 400 && pin_link_en[0] !== 1'b0; n++) @(posedge clk);
      chk("pull_imm", 32'h0, pin_link_en[0]);
      wr(`HSS_R_CTRL, 32'h2);
      rd_chk("err_pull", `HSS_R_STAT, 32'hFF, {24'h0, `HSS_ERR_STATE});
      chk("pull_src", 32'h0, pin_link_en[4]);
      $display("test hot-swap done");
      wr(`HSS_R_GLEN, 32'h5);
      wr(`HSS_R_GMUL, 32'h4);
      rd_chk("gdur", `HSS_R_GDUR, 32'hFFFF_FFFF, 32'd20);
      wr(`HSS_R_SIG0 + 8'h08, 32'h1C0);
      wr(`HSS_R_CTRL, 32'h4);
      wait_gl(1'b1, 400);
      chk("gl_once", 32'h1, glitch_active);
      @(posedge clk);
      chk("gl_drv", 32'h3, {pin_drv_oe[2], pin_drv_lvl[2]});
      for (k = 0; k < 5000 && glitch_active === 1'b1; k++) @(posedge clk);
      chk("gl_len", 32'h1, k >= 3990 && k <= 4010);
      wr(`HSS_R_CTRL, 32'h20);
      rd_chk("err_stop", `HSS_R_STAT, 32'hFF, {24'h0, `HSS_ERR_STATE});
      wr(`HSS_R_GLEN, 32'h1);
      wr(`HSS_R_GMUL, 32'h1);
      wr(`HSS_R_GCYC, 32'h7);
      rd_chk("gcyc", `HSS_R_GCYC, 32'hFFFF_FFFF, 32'h7);
      wr(`HSS_R_CTRL, 32'h8);
      wait_gl(1'b1, 3000);
      wait_gl(1'b0, 3000);
      wait_gl(1'b1, 3000);
      chk("gl_cyc", 32'h1, glitch_active);
      wr(`HSS_R_CTRL, 32'h20);
      rd_chk("stop_ok", `HSS_R_STAT, 32'hFF, 32'h0);
      wr(`HSS_R_GPRBS, 32'h2);
      rd_chk("prbs_t", `HSS_R_GPRBS, 32'h3, 32'h2);
      wr(`HSS_R_CTRL, 32'h10);
      wait_gl(1'b1, 20000);
      chk("gl_prbs", 32'h1, glitch_active);
      wr(`HSS_R_CTRL, 32'h20);
      $display("test glitch done");
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
